// ===== core/pil_pkg.sv
// constants, types and helpers shared by the interrupt line and pin bank
package pil_pkg;
    localparam int           NUM_FUNC       = 5;
    localparam int           FIRST_SEL_FUNC = 2;
    localparam int           NUM_SEL_FUNC   = 3;
    localparam int           NUM_INT_PINS   = 4;
    localparam int           PAIR_TIE_POS   = 29;
    localparam int           ALL_TIE_POS    = 28;
    localparam int           SEL_MSB        = 6;
    localparam int           SEL_LSB        = 5;
    localparam int           INTA_IDX       = 0;
    localparam int           INTB_IDX       = 1;
    localparam logic [7:0]   LINE_OFFSET    = 8'h3C;
    localparam logic [7:0]   PIN_OFFSET     = 8'h3D;
    localparam logic [7:0]   LINE_RESET     = 8'hFF;
    localparam logic [7:0]   PIN_INTA       = 8'h01;
    localparam logic [7:0]   PIN_INTB       = 8'h02;
    localparam logic [31:0]  ABSENT_READ    = 32'hFFFF_FFFF;
    localparam logic [31:0]  UNMAPPED_READ  = 32'h0000_0000;
    localparam logic [2:0]   FUNC_LIMIT     = 3'h5;

    typedef logic [7:0] pil_byte_type;

    typedef struct packed {
        pil_byte_type [NUM_FUNC-1:0] line;
        logic                        ack;
        logic [31:0]                 rdata;
    } pil_cfg_state_type;

    typedef struct packed {
        logic [NUM_INT_PINS-1:0] intReq;
    } pil_merge_state_type;

    // dword index of a configuration byte offset
    function automatic logic [5:0] pil_dword_of(input logic [7:0] off);
        return off[7:2];
    endfunction : pil_dword_of

    // byte lane of a configuration byte offset
    function automatic logic [1:0] pil_lane_of(input logic [7:0] off);
        return off[1:0];
    endfunction : pil_lane_of

    // select field 0..3 maps onto INTA..INTD codes 01h..04h
    function automatic pil_byte_type pil_pin_encode(input logic [1:0] sel);
        return {6'h00, sel} + PIN_INTA;
    endfunction : pil_pin_encode
endpackage : pil_pkg

// ===== core/pil_route_if.sv
// tie settings, select fields, pin codes and merged requests between bank and merger
`timescale 1ns/10ps
interface pil_route_if;
    import pil_pkg::*;
    logic                                 pairTie;
    logic                                 allTie;
    logic [NUM_SEL_FUNC-1:0][1:0]         intSel;
    logic [NUM_FUNC-1:0]                  funcIrq;
    pil_byte_type [NUM_FUNC-1:0]          pinValue;
    logic [NUM_INT_PINS-1:0]              intReq;

    modport bank  (output pairTie, output allTie, output intSel, output funcIrq,
                   input pinValue, input intReq);
    modport merge (input pairTie, input allTie, input intSel, input funcIrq,
                   output pinValue, output intReq);
endinterface : pil_route_if

// ===== core/pil_irq_merge.sv
// pin code per function and merging of function requests onto the shared lines
`timescale 1ns/10ps
module pil_irq_merge (
    input  wire logic  core_clk,
    input  wire logic  nrst,
    pil_route_if.merge route
);
    import pil_pkg::*;

    pil_merge_state_type state;
    pil_merge_state_type next_state;

    always_comb begin
        route.pinValue[0] = PIN_INTA;
        route.pinValue[1] = (route.pairTie || route.allTie) ? PIN_INTA : PIN_INTB;
        for (int f = FIRST_SEL_FUNC; f < NUM_FUNC; f++) begin
            // select fields reset to zero outside, so these start at INTA
            route.pinValue[f] = route.allTie ? PIN_INTA
                              : pil_pin_encode(route.intSel[f-FIRST_SEL_FUNC]);
        end
    end

    always_comb begin
        next_state = '0;
        for (int f = 0; f < NUM_FUNC; f++) begin
            if (route.funcIrq[f]) begin
                next_state.intReq[route.pinValue[f][1:0] - 2'h1] = 1'b1;
            end
        end
        // a function selecting INTB still lands on INTA when the pair is tied
        if (route.pairTie && next_state.intReq[INTB_IDX]) begin
            next_state.intReq[INTA_IDX] = 1'b1;
            next_state.intReq[INTB_IDX] = 1'b0;
        end
        if (route.allTie) begin
            next_state.intReq = {{(NUM_INT_PINS-1){1'b0}}, |route.funcIrq};
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign route.intReq = state.intReq;
endmodule : pil_irq_merge

// ===== core/pil_irq_bank.sv
// per-function interrupt line and interrupt pin configuration bytes
// How it works
// - each function has a writable line byte, reset FFh, holding what was written
// - pin byte is read-only everywhere; writes ignored, reads give function code
// - function 0 always reports INTA, 01h
// - function 1 reports INTB when both ties clear, otherwise INTA
// - pair-tie bit 29 set joins INTB onto INTA internally
// - all-tie bit 28 set merges all four lines; every function reports INTA
// - functions 2 to 4 report code from select bits 6-5, INTA at reset
// - pin codes always follow the live tie bits of the system control word
`timescale 1ns/10ps
module pil_irq_bank
    import pil_pkg::*;
(
    input  wire logic                          core_clk,
    input  wire logic                          nrst,
    input  wire logic                          cfgSel,
    input  wire logic                          cfgWrite,
    input  wire logic [2:0]                    cfgFunc,
    input  wire logic [5:0]                    cfgAddr,
    input  wire logic [3:0]                    cfgByteEn,
    input  wire logic [31:0]                   cfgWdata,
    output wire logic [31:0]                   cfgRdata,
    output wire logic                          cfgAck,
    input  wire logic [31:0]                   sysCtrlWord,
    input  wire logic [pil_pkg::NUM_SEL_FUNC-1:0][7:0] genCtrlLow,
    input  wire logic [pil_pkg::NUM_FUNC-1:0]  funcIrq,
    output wire logic [pil_pkg::NUM_INT_PINS-1:0] intReq
);
    import pil_pkg::*;

    localparam logic [1:0] LINE_LANE = pil_lane_of(LINE_OFFSET);
    localparam logic [1:0] PIN_LANE  = pil_lane_of(PIN_OFFSET);

    pil_cfg_state_type state;
    pil_cfg_state_type next_state;
    pil_route_if       route ();

    logic              funcValid;
    logic              hitIrqWord;
    logic              lineWrite;

    // tie bits are read straight from the system control word each cycle
    assign route.pairTie = sysCtrlWord[PAIR_TIE_POS];
    assign route.allTie  = sysCtrlWord[ALL_TIE_POS];
    assign route.funcIrq = funcIrq;

    always_comb begin
        for (int s = 0; s < NUM_SEL_FUNC; s++) begin
            route.intSel[s] = genCtrlLow[s][SEL_MSB:SEL_LSB];
        end
    end

    pil_irq_merge u_merge (
        .core_clk (core_clk),
        .nrst     (nrst),
        .route    (route.merge)
    );

    assign funcValid  = (cfgFunc < FUNC_LIMIT);
    assign hitIrqWord = (cfgAddr == pil_dword_of(LINE_OFFSET));
    assign lineWrite  = cfgSel && cfgWrite && funcValid && hitIrqWord && cfgByteEn[LINE_LANE];

    always_comb begin
        next_state       = state;
        next_state.ack   = cfgSel;
        next_state.rdata = UNMAPPED_READ;
        if (cfgSel && !cfgWrite) begin
            if (!funcValid) begin
                // absent functions read as all ones, like an unclaimed cycle
                next_state.rdata = ABSENT_READ;
            end else if (hitIrqWord) begin
                next_state.rdata[8*LINE_LANE +: 8] = state.line[cfgFunc];
                next_state.rdata[8*PIN_LANE +: 8]  = route.pinValue[cfgFunc];
            end
        end
        // only the line lane stores; the pin lane of a write is dropped
        if (lineWrite) begin
            next_state.line[cfgFunc] = cfgWdata[8*LINE_LANE +: 8];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state.line  <= {NUM_FUNC{LINE_RESET}};
            state.ack   <= 1'b0;
            state.rdata <= UNMAPPED_READ;
        end else begin
            state <= next_state;
        end
    end

    assign cfgRdata = state.rdata;
    assign cfgAck   = state.ack;
    // line bytes feed only the read path, never the request merge
    assign intReq   = route.intReq;

    // read decode for the checks below; the checks keep no state of their own
    logic              readHit;
    assign readHit = cfgSel && !cfgWrite && funcValid && hitIrqWord;

    property p_line_store;
        @(posedge core_clk) disable iff (!nrst)
        lineWrite |=> state.line[$past(cfgFunc)] == $past(cfgWdata[7:0]);
    endproperty
    a_line_store: assert property (p_line_store) else $error("line byte not stored");

    property p_line_hold;
        @(posedge core_clk) disable iff (!nrst)
        !lineWrite |=> state.line == $past(state.line);
    endproperty
    a_line_hold: assert property (p_line_hold) else $error("line byte changed");

    property p_func0_pin;
        @(posedge core_clk) disable iff (!nrst)
        route.pinValue[0] == PIN_INTA;
    endproperty
    a_func0_pin: assert property (p_func0_pin) else $error("function 0 not INTA");

    property p_func1_pin;
        @(posedge core_clk) disable iff (!nrst)
        route.pinValue[1] == ((route.pairTie || route.allTie) ? PIN_INTA : PIN_INTB);
    endproperty
    a_func1_pin: assert property (p_func1_pin) else $error("function 1 code wrong");

    property p_all_tie;
        @(posedge core_clk) disable iff (!nrst)
        route.allTie |-> route.pinValue == {NUM_FUNC{PIN_INTA}};
    endproperty
    a_all_tie: assert property (p_all_tie) else $error("all-tie codes wrong");

    property p_all_tie_merge;
        @(posedge core_clk) disable iff (!nrst)
        (route.allTie && |funcIrq) |=> intReq == 4'h1;
    endproperty
    a_all_tie_merge: assert property (p_all_tie_merge) else $error("lines not merged");

    property p_pair_tie;
        @(posedge core_clk) disable iff (!nrst)
        route.pairTie |=> !intReq[INTB_IDX];
    endproperty
    a_pair_tie: assert property (p_pair_tie) else $error("INTB live while tied");

    property p_sel_code;
        @(posedge core_clk) disable iff (!nrst)
        !route.allTie |-> route.pinValue[3] == {6'h00, genCtrlLow[1][SEL_MSB:SEL_LSB]} + 8'h01;
    endproperty
    a_sel_code: assert property (p_sel_code) else $error("select code wrong");

    property p_read_pin;
        @(posedge core_clk) disable iff (!nrst)
        readHit |=> cfgRdata[15:8] ==
            ($past(sysCtrlWord[ALL_TIE_POS]) ? PIN_INTA : $past(route.pinValue[cfgFunc]));
    endproperty
    a_read_pin: assert property (p_read_pin) else $error("pin read wrong");

    property p_ack;
        @(posedge core_clk) disable iff (!nrst)
        cfgSel |=> cfgAck;
    endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle after request");

    property p_ack_idle;
        @(posedge core_clk) disable iff (!nrst)
        !cfgSel |=> !cfgAck;
    endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack without request");

    property p_absent_read;
        @(posedge core_clk) disable iff (!nrst)
        cfgSel && !cfgWrite && !funcValid |=> cfgRdata == ABSENT_READ;
    endproperty
    a_absent_read: assert property (p_absent_read) else $error("absent function read wrong");

    property p_other_read;
        @(posedge core_clk) disable iff (!nrst)
        cfgSel && !cfgWrite && funcValid && !hitIrqWord |=> cfgRdata == UNMAPPED_READ;
    endproperty
    a_other_read: assert property (p_other_read) else $error("other offset read not zero");

    property p_write_quiet;
        @(posedge core_clk) disable iff (!nrst)
        cfgSel && cfgWrite |=> cfgRdata == UNMAPPED_READ;
    endproperty
    a_write_quiet: assert property (p_write_quiet) else $error("read data after write");

    property p_read_line;
        @(posedge core_clk) disable iff (!nrst)
        readHit |=> cfgRdata[7:0] == $past(state.line[cfgFunc]);
    endproperty
    a_read_line: assert property (p_read_line) else $error("line read wrong");

    property p_no_request;
        @(posedge core_clk) disable iff (!nrst)
        !(|funcIrq) |=> intReq == 4'h0;
    endproperty
    a_no_request: assert property (p_no_request) else $error("request without source");

    property p_rise_pair;
        @(posedge core_clk) disable iff (!nrst)
        $rose(route.pairTie) |-> route.pinValue[1] == PIN_INTA;
    endproperty
    a_rise_pair: assert property (p_rise_pair) else $error("pin code lags tie bit");

    property p_pair_fold;
        @(posedge core_clk) disable iff (!nrst)
        route.pairTie && funcIrq[3] && genCtrlLow[1][SEL_MSB:SEL_LSB] == 2'h1
            |=> intReq[INTA_IDX];
    endproperty
    a_pair_fold: assert property (p_pair_fold) else $error("INTB not folded");

    property p_sel_intb;
        @(posedge core_clk) disable iff (!nrst)
        !route.allTie && genCtrlLow[0][SEL_MSB:SEL_LSB] == 2'h1 |-> route.pinValue[2] == PIN_INTB;
    endproperty
    a_sel_intb: assert property (p_sel_intb) else $error("select INTB code wrong");

    property p_sel_func4;
        @(posedge core_clk) disable iff (!nrst)
        !route.allTie |->
            route.pinValue[4] == {6'h00, genCtrlLow[2][SEL_MSB:SEL_LSB]} + PIN_INTA;
    endproperty
    a_sel_func4: assert property (p_sel_func4) else $error("function 4 code wrong");
endmodule : pil_irq_bank

// ===== verif/pil_irq_bank_tb_top.sv
// self-checking testbench for the interrupt line and pin configuration bank
`timescale 1ns/10ps
module pil_irq_bank_tb_top;
    import pil_pkg::*;
    typedef struct packed {
        logic [1:0] tie;
        logic [1:0] sel;
        logic [2:0] func;
        logic [7:0] pin;
        logic [3:0] req;
    } pil_row_type;
    logic                           core_clk;
    logic                           nrst;
    logic                           cfgSel;
    logic                           cfgWrite;
    logic [2:0]                     cfgFunc;
    logic [5:0]                     cfgAddr;
    logic [3:0]                     cfgByteEn;
    logic [31:0]                    cfgWdata;
    logic [31:0]                    cfgRdata;
    logic                           cfgAck;
    logic [31:0]                    sysCtrlWord;
    logic [NUM_SEL_FUNC-1:0][7:0]   genCtrlLow;
    logic [NUM_FUNC-1:0]            funcIrq;
    logic [NUM_INT_PINS-1:0]        intReq;
    logic [31:0]                    rd;
    int                             fail_count = 0;
    int                             n_compared = 0;
    // tie pairs are {pair, all}; the select value goes to functions 2 to 4 alike
    pil_row_type rows [13] = '{
        '{2'b00, 2'd0, 3'd0, 8'h01, 4'h1}, '{2'b00, 2'd0, 3'd1, 8'h02, 4'h2},
        '{2'b00, 2'd0, 3'd2, 8'h01, 4'h1}, '{2'b00, 2'd1, 3'd3, 8'h02, 4'h2},
        '{2'b00, 2'd2, 3'd4, 8'h03, 4'h4}, '{2'b00, 2'd3, 3'd2, 8'h04, 4'h8},
        '{2'b10, 2'd0, 3'd1, 8'h01, 4'h1}, '{2'b10, 2'd1, 3'd3, 8'h02, 4'h1},
        '{2'b10, 2'd2, 3'd4, 8'h03, 4'h4}, '{2'b01, 2'd0, 3'd1, 8'h01, 4'h1},
        '{2'b01, 2'd3, 3'd3, 8'h01, 4'h1}, '{2'b11, 2'd2, 3'd4, 8'h01, 4'h1},
        '{2'b11, 2'd0, 3'd0, 8'h01, 4'h1}};

    pil_irq_bank u_pil_irq_bank (.core_clk(core_clk), .nrst(nrst), .cfgSel(cfgSel),
        .cfgWrite(cfgWrite), .cfgFunc(cfgFunc), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
        .cfgWdata(cfgWdata), .cfgRdata(cfgRdata), .cfgAck(cfgAck),
        .sysCtrlWord(sysCtrlWord), .genCtrlLow(genCtrlLow), .funcIrq(funcIrq),
        .intReq(intReq));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic cmp32(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp32

    task automatic cmp4(input string name, input logic [3:0] exp, input logic [3:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp4

    // one request, released at the edge that takes it; answer read while it stands
    task automatic cfg(input logic w, input logic [2:0] f, input logic [5:0] a,
                       input logic [3:0] be, input logic [31:0] d, output logic [31:0] r);
        @(posedge core_clk);
        cfgSel    <= 1'b1;
        cfgWrite  <= w;
        cfgFunc   <= f;
        cfgAddr   <= a;
        cfgByteEn <= be;
        cfgWdata  <= d;
        @(posedge core_clk);
        cfgSel <= 1'b0;
        #1;
        cmp4("ack", 4'h1, {3'h0, cfgAck});
        r = cfgRdata;
    endtask : cfg

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    initial begin
        #200us;
        fail_count++;
        conclude();
    end

    initial begin
        nrst = 1'b0;
        {cfgSel, cfgWrite, cfgFunc, cfgAddr, cfgByteEn, cfgWdata} = '0;
        sysCtrlWord = 32'h0000_0000;
        genCtrlLow = '0;
        funcIrq = '0;
        repeat (4) @(posedge core_clk);
        #1;
        cmp32("reset rdata", 32'h0000_0000, cfgRdata);
        cmp4("reset intReq", 4'h0, intReq);
        @(posedge core_clk);
        nrst <= 1'b1;
        for (int f = 0; f < NUM_FUNC; f++) begin
            cfg(1'b0, f[2:0], 6'h0F, 4'h0, 32'h0000_0000, rd);
            cmp32("reset line", {16'h0000, (f == 1) ? 8'h02 : 8'h01, 8'hFF}, rd);
        end
        $display("test reset done");
        // neighbouring bits set so a shifted field position shows up
        foreach (rows[i]) begin
            @(posedge core_clk);
            sysCtrlWord <= 32'h4800_0000 | {2'b00, rows[i].tie, 28'h000_0000};
            genCtrlLow  <= {3{8'h9F | {1'b0, rows[i].sel, 5'h00}}};
            funcIrq     <= 5'h01 << rows[i].func;
            cfg(1'b0, rows[i].func, 6'h0F, 4'h0, 32'h0000_0000, rd);
            cmp32("pin", {16'h0000, rows[i].pin, 8'hFF}, rd);
            cmp4("intReq", rows[i].req, intReq);
        end
        $display("test table done");
        @(posedge core_clk);
        sysCtrlWord <= 32'h0000_0000;
        genCtrlLow  <= '0;
        funcIrq     <= '0;
        for (int f = 0; f < NUM_FUNC; f++) begin
            cfg(1'b1, f[2:0], 6'h0F, 4'h3, {16'h0000, 8'h55, 8'h10 + f[7:0]}, rd);
            cfg(1'b0, f[2:0], 6'h0F, 4'h0, 32'h0000_0000, rd);
            cmp32("line", {16'h0000, (f == 1) ? 8'h02 : 8'h01, 8'h10 + f[7:0]}, rd);
        end
        cfg(1'b1, 3'd2, 6'h0F, 4'hE, 32'h0000_0077, rd);
        cfg(1'b0, 3'd2, 6'h0F, 4'h0, 32'h0000_0000, rd);
        cmp32("masked line", 32'h0000_0112, rd);
        cmp4("idle intReq", 4'h0, intReq);
        cfg(1'b1, 3'd5, 6'h0F, 4'hF, 32'h0000_0000, rd);
        cfg(1'b0, 3'd5, 6'h0F, 4'h0, 32'h0000_0000, rd);
        cmp32("absent", 32'hFFFF_FFFF, rd);
        cfg(1'b0, 3'd0, 6'h10, 4'h0, 32'h0000_0000, rd);
        cmp32("unmapped", 32'h0000_0000, rd);
        $display("test writes done");
        @(posedge core_clk);
        cfgSel    <= 1'b1;
        cfgWrite  <= 1'b1;
        cfgFunc   <= 3'd3;
        cfgAddr   <= 6'h0F;
        cfgByteEn <= 4'h1;
        cfgWdata  <= 32'h0000_003C;
        @(posedge core_clk);
        cfgWrite <= 1'b0;
        @(posedge core_clk);
        cfgSel <= 1'b0;
        #1;
        cmp32("back to back", 32'h0000_013C, cfgRdata);
        $display("test back to back done");
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        cfg(1'b0, 3'd3, 6'h0F, 4'h0, 32'h0000_0000, rd);
        cmp32("second reset", 32'h0000_01FF, rd);
        $display("test second reset done");
        conclude();
    end
endmodule : pil_irq_bank_tb_top
